// ---- shared/uof_pkg.sv ----
// Purpose: constants and types for the usb otg status and event flag block
// Assumes: 20 MHz core_clk, APB slave with 32-bit data
// Notes:   register offsets are byte addresses
package uof_pkg;
	localparam logic [11:0] OFS_OTG_STAT   = 12'h000;
	localparam logic [11:0] OFS_EVENT_FLAG = 12'h004;
	localparam logic [11:0] OFS_EVENT_MASK = 12'h008;
	localparam logic [11:0] OFS_ERR_ENABLE = 12'h00c;
	localparam logic [11:0] OFS_ERR_STAT   = 12'h010;
	localparam logic [11:0] OFS_XFER_RES   = 12'h014;

	localparam int BIT_VBUS_VALID  = 0;
	localparam int BIT_SESS_END    = 2;
	localparam int BIT_SESS_VALID  = 3;
	localparam int BIT_LINE_STABLE = 5;
	localparam int BIT_PLUG_TYPE   = 7;

	localparam int BIT_RESET  = 0;
	localparam int BIT_ERROR  = 1;
	localparam int BIT_SOF    = 2;
	localparam int BIT_TOKEN  = 3;
	localparam int BIT_IDLE   = 4;
	localparam int BIT_RESUME = 5;
	localparam int BIT_STALL  = 7;

	localparam logic [7:0] FLAG_IMPL = 8'hbf;
	localparam logic [7:0] FLAG_W1C  = 8'hbd;
	localparam logic [7:0] ZERO8     = 8'h00;

	localparam int CLK_HZ          = 20000000;
	localparam int K_STATE_NS      = 2500;
	localparam int RESET_HOLD_NS   = 2500;
	localparam int IDLE_MS         = 3;
	localparam int CLK_NS          = 1000000000 / CLK_HZ;
	localparam int K_STATE_CYC     = (K_STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_CYC        = IDLE_MS * (CLK_HZ / 1000);
	localparam int TMR_W           = 17;

	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_AW    = 2;
	localparam int RES_W      = 8;

	typedef enum logic [1:0] {
		LINE_SE0,
		LINE_J,
		LINE_K,
		LINE_SE1
	} uof_line_e;

	typedef struct packed {
		logic aVbusValid;
		logic sessionValid;
		logic bSessionEnd;
		logic lineStateStable;
		logic plugTypeFlag;
	} uof_otg_s;

	typedef struct packed {
		logic             stallSent;
		logic             sofSeen;
		logic             tokenDone;
		logic [RES_W-1:0] tokenResult;
		logic [7:0]       errEvents;
	} uof_evt_s;
endpackage

// ---- logic/uof_line_timer.sv ----
// Purpose: counts consecutive cycles of a condition and pulses once at a threshold
// Assumes: cond is already synchronous to core_clk
// Notes:   re-arms only after cond falls
`timescale 1ns/1ps
module uof_line_timer #(
	parameter int LIMIT = 50
) (
	// clock and control
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clkEn,
	// condition and result
	input  wire logic cond,
	output logic      hit
);
	logic [uof_pkg::TMR_W-1:0] cnt_ff;
	logic                      done_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff  <= '0;
			done_ff <= 1'b0;
			hit     <= 1'b0;
		end else if (clkEn) begin
			hit <= 1'b0;
			if (!cond) begin
				cnt_ff  <= '0;
				done_ff <= 1'b0;
			end else if (!done_ff) begin
				if (cnt_ff == uof_pkg::TMR_W'(LIMIT - 1)) begin
					hit     <= 1'b1;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 1'b1;
				end
			end
		end
	end
endmodule

// ---- logic/uof_status_flags.sv ----
// Purpose: otg bus status and device event flags behind an APB slave
// Assumes: line and comparator pins are asynchronous; engine events are core_clk pulses
// Notes:   one level interrupt from flags gated by the mask register
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module uof_status_flags #(
	parameter int IDLE_CYCLES = uof_pkg::IDLE_CYC
) (
	// clock, reset, enable
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic                       clkEn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// asynchronous bus-side inputs
	input  wire uof_pkg::uof_otg_s          otgPins,
	input  wire logic [1:0]                 lineState,
	input  wire logic                       lowSpeed,
	// engine events, core_clk domain
	input  wire uof_pkg::uof_evt_s          engineEvt,
	// interrupt
	output logic                            usbIrq
);
	// pin synchronisers
	uof_pkg::uof_otg_s otgMeta_ff;
	uof_pkg::uof_otg_s otgSync_ff;
	logic [1:0]        lineMeta_ff;
	logic [1:0]        lineSync_ff;
	logic              lsMeta_ff;
	logic              lsSync_ff;

	// registers
	logic [7:0]                 usb_event_flags_ff;
	logic [7:0]                 eventMask_ff;
	logic [7:0]                 error_enable_mask_ff;
	logic [7:0]                 errStat_ff;
	logic [7:0]                 otg_bus_status_ff;
	logic [uof_pkg::RES_W-1:0]  resFifo_ff [uof_pkg::FIFO_DEPTH];
	logic [uof_pkg::FIFO_AW-1:0] rdPtr_ff;
	logic [uof_pkg::FIFO_AW-1:0] wrPtr_ff;
	logic [uof_pkg::FIFO_AW:0]   count_ff;
	logic                       resetArmed_ff;

	// combinational, plus the registered hit pulses of the line timers
	logic       kState;
	logic       busIdle;
	logic       busReset;
	logic       resumeHit;
	logic       idleHit;
	logic       resetHit;
	logic       wrStrobe;
	logic       rdStrobe;
	logic [7:0] nxt_flags;
	logic [7:0] setVec;
	logic [7:0] clrVec;
	logic [7:0] clrErr;
	logic [31:0] nxt_prdata;
	logic       nxt_slverr;
	logic       popFifo;
	logic       pushFifo;

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
		is_reg = (a == ofs);
	endfunction

	function automatic logic known_addr(input logic [11:0] a);
		known_addr = is_reg(a, uof_pkg::OFS_OTG_STAT) || is_reg(a, uof_pkg::OFS_EVENT_FLAG)
			|| is_reg(a, uof_pkg::OFS_EVENT_MASK) || is_reg(a, uof_pkg::OFS_ERR_ENABLE)
			|| is_reg(a, uof_pkg::OFS_ERR_STAT) || is_reg(a, uof_pkg::OFS_XFER_RES);
	endfunction

	// two-flop synchronisers for pins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otgMeta_ff  <= '0;
			otgSync_ff  <= '0;
			lineMeta_ff <= '0;
			lineSync_ff <= '0;
			lsMeta_ff   <= 1'b0;
			lsSync_ff   <= 1'b0;
		end else if (clkEn) begin
			otgMeta_ff  <= otgPins;
			otgSync_ff  <= otgMeta_ff;
			lineMeta_ff <= lineState;
			lineSync_ff <= lineMeta_ff;
			lsMeta_ff   <= lowSpeed;
			lsSync_ff   <= lsMeta_ff;
		end
	end

	// line condition decode; k and j are fixed line codes, the synchronised lowSpeed is not used
	always_comb begin
		kState   = (lineSync_ff == uof_pkg::LINE_K);
		busIdle  = (lineSync_ff == uof_pkg::LINE_J);
		busReset = (lineSync_ff == uof_pkg::LINE_SE0);
	end

	uof_line_timer #(
		.LIMIT(uof_pkg::K_STATE_CYC)
	) u_resume (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.cond     (kState),
		.hit      (resumeHit)
	);

	uof_line_timer #(
		.LIMIT(IDLE_CYCLES)
	) u_idle (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.cond     (busIdle),
		.hit      (idleHit)
	);

	uof_line_timer #(
		.LIMIT(uof_pkg::RESET_HOLD_CYC)
	) u_reset (
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn),
		.cond     (busReset),
		.hit      (resetHit)
	);

	// otg status register mirrors synchronised comparator and pin levels
	always_ff @(posedge core_clk) begin
		if (rst) begin
			otg_bus_status_ff <= '0;
		end else if (clkEn) begin
			otg_bus_status_ff                            <= '0;
			otg_bus_status_ff[uof_pkg::BIT_VBUS_VALID]  <= otgSync_ff.aVbusValid;
			otg_bus_status_ff[uof_pkg::BIT_SESS_VALID]  <= otgSync_ff.sessionValid;
			otg_bus_status_ff[uof_pkg::BIT_SESS_END]    <= otgSync_ff.bSessionEnd;
			otg_bus_status_ff[uof_pkg::BIT_LINE_STABLE] <= otgSync_ff.lineStateStable;
			otg_bus_status_ff[uof_pkg::BIT_PLUG_TYPE]   <= otgSync_ff.plugTypeFlag;
		end
	end

	// apb decode, zero wait states
	always_comb begin
		wrStrobe = psel && penable && pwrite;
		rdStrobe = psel && penable && !pwrite;
	end

	// write-one-to-clear masks, only when byte lane 0 (pstrb[0]) is written
	always_comb begin
		clrVec = '0;
		clrErr = '0;
		if (wrStrobe && (pstrb[0] == 1'b1)) begin
			if (is_reg(paddr, uof_pkg::OFS_EVENT_FLAG)) begin
				clrVec = pwdata[7:0] & uof_pkg::FLAG_W1C;
			end
			if (is_reg(paddr, uof_pkg::OFS_ERR_STAT)) begin
				clrErr = pwdata[7:0];
			end
		end
	end

	// fifo pops when a set token flag is cleared
	always_comb begin
		popFifo  = clrVec[uof_pkg::BIT_TOKEN] && usb_event_flags_ff[uof_pkg::BIT_TOKEN];
		pushFifo = engineEvt.tokenDone && (count_ff != (uof_pkg::FIFO_AW+1)'(uof_pkg::FIFO_DEPTH));
	end

	// event set vector; set wins over a clear in the same cycle
	always_comb begin
		setVec                      = '0;
		setVec[uof_pkg::BIT_STALL]  = engineEvt.stallSent;
		setVec[uof_pkg::BIT_RESUME] = resumeHit;
		setVec[uof_pkg::BIT_IDLE]   = idleHit;
		setVec[uof_pkg::BIT_SOF]    = engineEvt.sofSeen;
		setVec[uof_pkg::BIT_RESET]  = resetHit && resetArmed_ff;
		nxt_flags = (usb_event_flags_ff & ~clrVec) | setVec;
		// token flag stays set while further results wait in the fifo
		nxt_flags[uof_pkg::BIT_TOKEN] = (count_ff > (uof_pkg::FIFO_AW+1)'(popFifo ? 1 : 0))
			|| pushFifo;
		nxt_flags[uof_pkg::BIT_ERROR] = |(errStat_ff & error_enable_mask_ff);
		nxt_flags = nxt_flags & uof_pkg::FLAG_IMPL;
	end

	// bus reset flag re-arms only once the bus leaves se0
	always_ff @(posedge core_clk) begin
		if (rst) begin
			resetArmed_ff <= 1'b1;
		end else if (clkEn) begin
			if (!busReset) begin
				resetArmed_ff <= 1'b1;
			end else if (resetHit) begin
				resetArmed_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			usb_event_flags_ff <= uof_pkg::ZERO8;
		end else if (clkEn) begin
			usb_event_flags_ff <= nxt_flags;
		end
	end

	// raw error status, sticky with write-one-to-clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			errStat_ff <= uof_pkg::ZERO8;
		end else if (clkEn) begin
			errStat_ff <= (errStat_ff & ~clrErr) | engineEvt.errEvents;
		end
	end

	// software-written mask and error enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			eventMask_ff         <= uof_pkg::ZERO8;
			error_enable_mask_ff <= uof_pkg::ZERO8;
		end else if (clkEn && wrStrobe && pstrb[0]) begin
			if (is_reg(paddr, uof_pkg::OFS_EVENT_MASK)) begin
				eventMask_ff <= pwdata[7:0] & uof_pkg::FLAG_IMPL;
			end
			if (is_reg(paddr, uof_pkg::OFS_ERR_ENABLE)) begin
				error_enable_mask_ff <= pwdata[7:0];
			end
		end
	end

	// transfer result fifo, flip-flop storage
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdPtr_ff <= '0;
			wrPtr_ff <= '0;
			count_ff <= '0;
			for (int i = 0; i < uof_pkg::FIFO_DEPTH; i++) begin
				resFifo_ff[i] <= '0;
			end
		end else if (clkEn) begin
			if (pushFifo) begin
				resFifo_ff[wrPtr_ff] <= engineEvt.tokenResult;
				wrPtr_ff             <= wrPtr_ff + 1'b1;
			end
			if (popFifo) begin
				rdPtr_ff <= rdPtr_ff + 1'b1;
			end
			count_ff <= count_ff + (uof_pkg::FIFO_AW+1)'(pushFifo) - (uof_pkg::FIFO_AW+1)'(popFifo);
		end
	end

	// read mux
	always_comb begin
		nxt_prdata = '0;
		nxt_slverr = !known_addr(paddr);
		unique case (1'b1)
			is_reg(paddr, uof_pkg::OFS_OTG_STAT):   nxt_prdata[7:0] = otg_bus_status_ff;
			is_reg(paddr, uof_pkg::OFS_EVENT_FLAG): nxt_prdata[7:0] = usb_event_flags_ff;
			is_reg(paddr, uof_pkg::OFS_EVENT_MASK): nxt_prdata[7:0] = eventMask_ff;
			is_reg(paddr, uof_pkg::OFS_ERR_ENABLE): nxt_prdata[7:0] = error_enable_mask_ff;
			is_reg(paddr, uof_pkg::OFS_ERR_STAT):   nxt_prdata[7:0] = errStat_ff;
			is_reg(paddr, uof_pkg::OFS_XFER_RES):   nxt_prdata[7:0] = resFifo_ff[rdPtr_ff];
			default:                                nxt_prdata = '0;
		endcase
	end

	// apb answer registered: ready in the cycle after the setup phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (clkEn) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && nxt_slverr;
			if (psel && !penable && !pwrite) begin
				prdata <= nxt_prdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			usbIrq <= 1'b0;
		end else if (clkEn) begin
			usbIrq <= |(nxt_flags & eventMask_ff);
		end
	end
endmodule

// ---- verification/uof_status_flags_props.sv ----
// Purpose: port checks of the status flag block
// Assumes: apb master holds each request until pready
// Notes:   bound to every uof_status_flags instance
`timescale 1ns/1ps
module uof_flags_props (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              clkEn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// bus side and interrupt
	input wire uof_pkg::uof_otg_s otgPins,
	input wire logic              usbIrq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_reset_quiet:
		assert property (disable iff (1'b0) rst |=> !usbIrq && !pready && prdata == 32'h0) else $error("busy after reset");
	a_ready_follows:
		assert property (psel && !penable && clkEn |=> pready) else $error("no ready after setup");
	a_ready_single:
		assert property (pready |=> !pready) else $error("ready held too long");
	a_unmapped_err:
		assert property (pready && paddr > 12'h014 |-> pslverr && (pwrite || prdata == 32'h0))
			else $error("unmapped not refused");
	a_mapped_ok:
		assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
	a_unused_zero:
		assert property (pready && !pwrite |-> prdata[31:8] == 24'h0
			&& !(paddr == uof_pkg::OFS_EVENT_FLAG && prdata[6])) else $error("unused bit set");
	a_otg_follow:
		assert property (($stable(otgPins) [*6]) ##0 (pready && !pwrite && paddr == uof_pkg::OFS_OTG_STAT)
			|-> prdata[0] == otgPins.aVbusValid && prdata[3] == otgPins.sessionValid
			&& prdata[7] == otgPins.plugTypeFlag) else $error("otg status off pins");
	a_irq_masked:
		assert property (pready && pwrite && pstrb[0] && paddr == uof_pkg::OFS_EVENT_MASK && pwdata[7:0] == 8'h00
			|=> ##1 !usbIrq [*3]) else $error("irq with empty mask");
endmodule
bind uof_status_flags uof_flags_props u_props (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .otgPins(otgPins), .usbIrq(usbIrq));

// ---- verification/uof_host_model.sv ----
// Purpose: usb host side line driver
// Assumes: line code already speed-adjusted
// Notes:   pull-up gives j while the host is quiet
`timescale 1ns/1ps
module uof_host_model (
	// clock
	input wire logic   core_clk,
	// bus line
	output logic [1:0] lineState
);
	initial lineState = uof_pkg::LINE_J;
	// k for resume, se0 for bus reset, j for idle
	task automatic drive(input uof_pkg::uof_line_e s, input int n);
		lineState <= s;
		repeat (n) @(posedge core_clk);
	endtask
endmodule

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for the status flag block
// Assumes: 20 MHz core_clk, short idle count
// Notes:   idle flag masked outside its own test
`timescale 1ns/1ps
module tb_top;
	logic              core_clk, rst, psel, penable, pwrite, pready, pslverr, usbIrq, er, clkEn;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, r, lfsr;
	logic [1:0]        lineState;
	uof_pkg::uof_otg_s otgPins;
	uof_pkg::uof_evt_s evt;
	int                n_mismatch = 0, n_checks = 0, mFlag = 0, mErr = 0, mEn = 0;
	int                mFifo[$];
	uof_status_flags #(.IDLE_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .otgPins(otgPins), .lineState(lineState), .lowSpeed(1'b0),
		.engineEvt(evt), .usbIrq(usbIrq));
	uof_host_model host (.core_clk(core_clk), .lineState(lineState));
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	function automatic int expF();
		return (mFlag | (mFifo.size() != 0 ? 8 : 0) | ((mErr & mEn) != 0 ? 2 : 0)) & 8'hef;
	endfunction
	task automatic flags();
		apb(0, uof_pkg::OFS_EVENT_FLAG, 0);
		chk("flags", r & 32'hef, expF());
	endtask
	task automatic clr(input int b);
		apb(1, uof_pkg::OFS_EVENT_FLAG, b);
		mFlag &= ~b;
		if (b[3] && mFifo.size() != 0) void'(mFifo.pop_front());
	endtask
	task automatic pulse(input uof_pkg::uof_evt_s e);
		@(posedge core_clk);
		evt <= e;
		@(posedge core_clk);
		evt <= '0;
		mFlag |= (e.stallSent ? 8'h80 : 0) | (e.sofSeen ? 4 : 0);
		mErr |= e.errEvents;
		if (e.tokenDone && mFifo.size() < 4) mFifo.push_back(e.tokenResult);
	endtask
	task automatic chk_reset();
		for (int a = 0; a <= 'h14; a += 4) begin
			apb(0, a[11:0], 0);
			chk("reset", r & 32'hef, 0);
		end
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rst = 1;
		clkEn = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		otgPins = '0;
		evt = '0;
		lfsr = 32'h30a2;
		repeat (12) @(posedge core_clk);
		rst <= 0;
		chk_reset();
		repeat (4) begin
			lfsr = nxt(lfsr);
			otgPins <= lfsr[4:0];
			repeat (8) @(posedge core_clk);
			apb(0, uof_pkg::OFS_OTG_STAT, 0);
			chk("otg", r, {24'h0, lfsr[0], 1'b0, lfsr[1], 1'b0, lfsr[3], lfsr[2], 1'b0, lfsr[4]});
		end
		pulse('{1'b1, 1'b1, 1'b0, 8'h0, 8'h0});
		repeat (5) @(posedge core_clk);
		flags();
		clr(0);
		flags();
		clr(8'h84);
		flags();
		pulse('{1'b1, 1'b1, 1'b0, 8'h0, 8'h0});
		flags();
		apb(1, uof_pkg::OFS_EVENT_FLAG, r | 32'h01);
		mFlag = 0;
		flags();
		apb(1, uof_pkg::OFS_EVENT_MASK, 32'h80);
		pulse('{1'b1, 1'b0, 1'b0, 8'h0, 8'h0});
		repeat (3) @(posedge core_clk);
		chk("irq", usbIrq, 1);
		clr(8'h80);
		repeat (3) @(posedge core_clk);
		chk("irq", usbIrq, 0);
		apb(1, uof_pkg::OFS_EVENT_MASK, 0);
		pulse('{1'b1, 1'b0, 1'b0, 8'h0, 8'h0});
		repeat (3) @(posedge core_clk);
		chk("irq", usbIrq, 0);
		clr(8'h80);
		@(posedge core_clk);
		clkEn <= 0;
		evt <= '{1'b1, 1'b1, 1'b0, 8'h0, 8'h0};
		@(posedge core_clk);
		clkEn <= 1;
		evt <= '0;
		flags();
		host.drive(uof_pkg::LINE_K, 40);
		host.drive(uof_pkg::LINE_J, 4);
		flags();
		host.drive(uof_pkg::LINE_K, 60);
		host.drive(uof_pkg::LINE_J, 4);
		mFlag |= 8'h20;
		flags();
		clr(8'h20);
		host.drive(uof_pkg::LINE_SE0, 60);
		mFlag |= 1;
		flags();
		clr(1);
		host.drive(uof_pkg::LINE_SE0, 80);
		flags();
		host.drive(uof_pkg::LINE_J, 4);
		host.drive(uof_pkg::LINE_SE0, 60);
		host.drive(uof_pkg::LINE_J, 4);
		mFlag |= 1;
		flags();
		clr(1);
		host.drive(uof_pkg::LINE_K, 5);
		clr(8'h10);
		host.drive(uof_pkg::LINE_J, 8);
		apb(0, uof_pkg::OFS_EVENT_FLAG, 0);
		chk("idle", r[4], 0);
		host.drive(uof_pkg::LINE_J, 30);
		apb(0, uof_pkg::OFS_EVENT_FLAG, 0);
		chk("idle", r[4], 1);
		repeat (5) begin
			lfsr = nxt(lfsr);
			pulse('{1'b0, 1'b0, 1'b1, lfsr[7:0], 8'h0});
		end
		while (mFifo.size() != 0) begin
			flags();
			apb(0, uof_pkg::OFS_XFER_RES, 0);
			chk("result", r, mFifo[0]);
			clr(8);
		end
		flags();
		pulse('{1'b0, 1'b0, 1'b0, 8'h0, 8'h04});
		flags();
		apb(1, uof_pkg::OFS_ERR_ENABLE, 32'h04);
		mEn = 4;
		flags();
		clr(2);
		flags();
		apb(1, uof_pkg::OFS_ERR_STAT, 32'hff);
		mErr = 0;
		flags();
		apb(1, 12'h020, 32'hff);
		apb(0, 12'h020, 0);
		chk("slverr", er, 1);
		chk("unmapped", r, 0);
		apb(1, uof_pkg::OFS_EVENT_MASK, 32'h80);
		pulse('{1'b1, 1'b0, 1'b1, 8'h5a, 8'h01});
		repeat (2) @(posedge core_clk);
		chk("irq", usbIrq, 1);
		rst <= 1;
		otgPins <= '0;
		repeat (12) @(posedge core_clk);
		rst <= 0;
		mFlag = 0;
		mErr = 0;
		mEn = 0;
		mFifo.delete();
		chk("irq", usbIrq, 0);
		chk_reset();
		report_and_stop();
	end
endmodule
